// [core/vnr_rx_framer.sv]
`timescale 1ns/1ps
module vnr_rx_framer #(
  parameter int LEN_W = 17
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // packet framing request
  input wire logic i_pkt_req,
  output logic o_pkt_ready,
  input wire logic [LEN_W-1:0] i_pkt_len,
  input wire logic [LEN_W-1:0] i_buf_len,
  input wire vnr_pkg::vnr_off_t i_pkt_off,
  input wire logic i_pkt_ecn,
  input wire logic [15:0] i_pkt_mss,
  input wire logic [15:0] i_pkt_hdr_len,
  input wire logic i_csum_partial,
  input wire logic i_csum_checked,
  input wire logic i_csum_verified,
  input wire logic [15:0] i_csum_start,
  input wire logic [15:0] i_csum_offset,
  input wire logic [15:0] i_rsc_segs,
  input wire logic [15:0] i_rsc_dups,
  // buffer fill and header output
  output logic o_buf_valid,
  output logic [LEN_W-1:0] o_buf_len,
  output logic o_hdr_valid,
  output logic [7:0] o_hdr_flags,
  output logic [7:0] o_hdr_gso_type,
  output logic [15:0] o_hdr_len,
  output logic [15:0] o_hdr_gso_size,
  output logic [15:0] o_hdr_csum_start,
  output logic [15:0] o_hdr_csum_offset,
  output logic [15:0] o_hdr_num_buffers,
  output logic o_pkt_drop,
  // control command byte stream
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_byte,
  input wire logic i_cmd_last,
  output logic o_ack_valid,
  output logic [7:0] o_ack_byte,
  // receive filter lookup
  input wire logic i_filt_req,
  input wire vnr_pkg::vnr_dst_t i_filt_dst,
  input wire logic i_filt_addr_match,
  output logic o_filt_valid,
  output logic o_filt_pass
);
  import vnr_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  logic [FEAT_W-1:0] feat_r;
  logic promisc_r, allmulti_r, alluni_r, nomulti_r, nouni_r, nobcast_r;
  logic [31:0] pkt_cnt_r, drop_cnt_r;
  vnr_state_t state_r;
  logic [LEN_W:0] rem_r;
  logic [LEN_W-1:0] blen_r;
  logic [15:0] nbuf_r;
  logic [7:0] flags_r, gso_r;
  logic [15:0] hlen_r, mss_r, cstart_r, coff_r;
  logic [1:0] cmd_cnt_r;
  logic [7:0] cmd_cls_r, cmd_code_r;

  // header fields worked out from request and negotiated features
  logic any_seg, off_ok, gso_on, ecn_bad, too_big, buf_bad, take;
  logic needs, dv, rsc;
  logic [7:0] gso_nxt, flags_nxt;
  logic [LEN_W:0] total;
  always_comb
  begin
    any_seg = feat_r[F_TSO4] | feat_r[F_TSO6] | feat_r[F_UFO];
    case (i_pkt_off)
      VNR_OFF_TCP4: off_ok = feat_r[F_TSO4];
      VNR_OFF_TCP6: off_ok = feat_r[F_TSO6];
      VNR_OFF_UDP: off_ok = feat_r[F_UFO];
      default: off_ok = 1'b0;
    endcase
    // offload only reported with its own feature and checksum support
    gso_on = off_ok & feat_r[F_CSUM]; // see RULE5
    ecn_bad = gso_on & i_pkt_ecn & ~feat_r[F_ECN]; // see RULE6
    case (i_pkt_off)
      VNR_OFF_TCP4: gso_nxt = GSO_TCPV4;
      VNR_OFF_TCP6: gso_nxt = GSO_TCPV6;
      VNR_OFF_UDP: gso_nxt = GSO_UDP;
      default: gso_nxt = GSO_NONE;
    endcase
    if (!gso_on)
      gso_nxt = GSO_NONE; // see RULE5
    else if (i_pkt_ecn)
      gso_nxt = gso_nxt | GSO_ECN; // see RULE6
    // needs-checksum only on a validated partial sum, forced by offload
    needs = feat_r[F_CSUM] & (gso_on | (i_csum_partial & i_csum_checked));
    dv = feat_r[F_CSUM] & i_csum_verified & ~needs; // see RULE11
    rsc = feat_r[F_RSC] & gso_on; // see RULE9
    flags_nxt = 8'h00; // see RULE4
    if (needs)
      flags_nxt = flags_nxt | FLG_NEEDS_CSUM; // see RULE7 RULE8
    if (dv)
      flags_nxt = flags_nxt | FLG_DATA_VALID;
    if (rsc)
      flags_nxt = flags_nxt | FLG_RSC_INFO;
    total = {1'b0, i_pkt_len} + (LEN_W+1)'(HDR_BYTES);
    // a buffer smaller than the header is refused; a zero-length one would never make progress
    buf_bad = i_buf_len < LEN_W'(HDR_BYTES);
    too_big = ~feat_r[F_MRG] & (total > {1'b0, i_buf_len}); // see RULE1
    take = i_pkt_req & (state_r == VNR_ST_IDLE);
  end

  assign o_pkt_ready = (state_r == VNR_ST_IDLE);

  // framing state machine: split, then header and used commit
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      state_r <= VNR_ST_IDLE;
    else
      case (state_r)
        VNR_ST_IDLE:
          if (take && !(ecn_bad || too_big || buf_bad))
            state_r <= VNR_ST_SPLIT;
        VNR_ST_SPLIT:
          if (rem_r <= {1'b0, blen_r})
            state_r <= VNR_ST_HDR;
        VNR_ST_HDR:
          state_r <= VNR_ST_IDLE;
        default:
          state_r <= VNR_ST_IDLE;
      endcase
  end

  // latch header fields at acceptance
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      flags_r <= 8'h00;
      gso_r <= GSO_NONE;
      hlen_r <= 16'h0000;
      mss_r <= 16'h0000;
      cstart_r <= 16'h0000;
      coff_r <= 16'h0000;
      blen_r <= '0;
    end
    else if (take)
    begin
      flags_r <= flags_nxt;
      gso_r <= gso_nxt;
      hlen_r <= any_seg ? i_pkt_hdr_len : 16'h0000; // see RULE10
      mss_r <= gso_on ? i_pkt_mss : 16'h0000; // see RULE8
      // coalescing counts reuse the checksum fields
      cstart_r <= rsc ? i_rsc_segs : (needs ? i_csum_start : 16'h0000);
      coff_r <= rsc ? i_rsc_dups : (needs ? i_csum_offset : 16'h0000);
      blen_r <= i_buf_len;
    end
  end

  // buffer walk: every buffer but the last is filled to its full length
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rem_r <= '0;
      nbuf_r <= 16'h0000;
      o_buf_valid <= 1'b0;
      o_buf_len <= '0;
    end
    else
    begin
      o_buf_valid <= 1'b0;
      if (take)
      begin
        rem_r <= total;
        nbuf_r <= 16'h0000;
      end
      else if (state_r == VNR_ST_SPLIT)
      begin
        o_buf_valid <= 1'b1;
        if (rem_r > {1'b0, blen_r})
        begin
          o_buf_len <= blen_r; // see RULE2
          rem_r <= rem_r - {1'b0, blen_r};
        end
        else
        begin
          o_buf_len <= rem_r[LEN_W-1:0];
          rem_r <= '0;
        end
        nbuf_r <= nbuf_r + 16'h0001; // see RULE1
      end
    end
  end

  // header and used commit leave in one pulse after the last buffer
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_hdr_valid <= 1'b0;
      o_hdr_flags <= 8'h00;
      o_hdr_gso_type <= GSO_NONE;
      o_hdr_len <= 16'h0000;
      o_hdr_gso_size <= 16'h0000;
      o_hdr_csum_start <= 16'h0000;
      o_hdr_csum_offset <= 16'h0000;
      o_hdr_num_buffers <= 16'h0000;
      o_pkt_drop <= 1'b0;
    end
    else
    begin
      o_hdr_valid <= (state_r == VNR_ST_HDR); // see RULE3
      o_pkt_drop <= take & (ecn_bad | too_big | buf_bad); // see RULE6
      if (state_r == VNR_ST_HDR)
      begin
        o_hdr_flags <= flags_r;
        o_hdr_gso_type <= gso_r;
        o_hdr_len <= hlen_r;
        o_hdr_gso_size <= mss_r;
        o_hdr_csum_start <= cstart_r;
        o_hdr_csum_offset <= coff_r;
        o_hdr_num_buffers <= nbuf_r; // see RULE1
      end
    end
  end

  // control command parser: class, code, one data byte, then ack
  logic cmd_ok, cmd_end;
  always_comb
  begin
    cmd_end = i_cmd_valid & i_cmd_last;
    cmd_ok = (cmd_cnt_r == 2'd2) && (cmd_cls_r == CLS_RX)
      && (i_cmd_byte <= 8'h01); // see RULE16
    if (cmd_code_r <= CMD_ALLMULTI)
      cmd_ok = cmd_ok & feat_r[F_CRX]; // see RULE17
    else if (cmd_code_r <= CMD_NOBCAST)
      cmd_ok = cmd_ok & feat_r[F_CRXX]; // see RULE19
    else
      cmd_ok = 1'b0;
  end

  // byte counter saturates so long commands still end in an error
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cmd_cnt_r <= 2'd0;
      cmd_cls_r <= 8'h00;
      cmd_code_r <= 8'h00;
    end
    else if (i_cmd_valid)
    begin
      if (cmd_cnt_r == 2'd0)
        cmd_cls_r <= i_cmd_byte;
      if (cmd_cnt_r == 2'd1)
        cmd_code_r <= i_cmd_byte;
      if (i_cmd_last)
        cmd_cnt_r <= 2'd0;
      else if (cmd_cnt_r != 2'd3)
        cmd_cnt_r <= cmd_cnt_r + 2'd1;
    end
  end

  // ack byte goes back one cycle after the last command byte
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_ack_valid <= 1'b0;
      o_ack_byte <= ACK_OK;
    end
    else
    begin
      o_ack_valid <= cmd_end;
      if (cmd_end)
        o_ack_byte <= cmd_ok ? ACK_OK : ACK_ERR; // see RULE16
    end
  end

  // filter mode flags, changed only by accepted commands
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      promisc_r <= 1'b0;
      allmulti_r <= 1'b0;
      alluni_r <= 1'b0;
      nomulti_r <= 1'b0;
      nouni_r <= 1'b0;
      nobcast_r <= 1'b0;
    end
    else if (cmd_end && cmd_ok)
      case (cmd_code_r)
        CMD_PROMISC: promisc_r <= i_cmd_byte[0]; // see RULE17
        CMD_ALLMULTI: allmulti_r <= i_cmd_byte[0]; // see RULE17
        CMD_ALLUNI: alluni_r <= i_cmd_byte[0]; // see RULE19
        CMD_NOMULTI: nomulti_r <= i_cmd_byte[0]; // see RULE20
        CMD_NOUNI: nouni_r <= i_cmd_byte[0]; // see RULE21
        CMD_NOBCAST: nobcast_r <= i_cmd_byte[0]; // see RULE22
        default: promisc_r <= promisc_r;
      endcase
  end

  // filter decision; suppressors beat the all-modes, promiscuous beats both
  logic pass_nxt;
  always_comb
  begin
    case (i_filt_dst)
      VNR_DST_BCAST: pass_nxt = ~nobcast_r; // see RULE20 RULE22
      VNR_DST_MULTI:
        pass_nxt = ~nomulti_r & (allmulti_r | i_filt_addr_match); // see RULE20
      default:
        pass_nxt = ~nouni_r & (alluni_r | i_filt_addr_match); // see RULE21
    endcase
    if (promisc_r)
      pass_nxt = 1'b1; // see RULE18
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_filt_valid <= 1'b0;
      o_filt_pass <= 1'b0;
    end
    else
    begin
      o_filt_valid <= i_filt_req;
      if (i_filt_req)
        o_filt_pass <= pass_nxt;
    end
  end

  // feature register and statistics
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      feat_r <= FEAT_RST;
      pkt_cnt_r <= 32'h0000_0000;
      drop_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      if (i_reg_wr && i_reg_addr == REG_FEATURES)
        feat_r <= i_reg_wdata[FEAT_W-1:0];
      if (state_r == VNR_ST_HDR)
        pkt_cnt_r <= pkt_cnt_r + 32'h0000_0001;
      if (take && (ecn_bad || too_big || buf_bad))
        drop_cnt_r <= drop_cnt_r + 32'h0000_0001;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_reg_rdata <= 32'h0000_0000;
    else if (!i_reg_rd)
      o_reg_rdata <= 32'h0000_0000;
    else
      case (i_reg_addr)
        REG_FEATURES: o_reg_rdata <= {23'h00_0000, feat_r};
        REG_FILTER: o_reg_rdata <= {26'h000_0000, nobcast_r, nouni_r,
          nomulti_r, alluni_r, allmulti_r, promisc_r};
        REG_PKT_CNT: o_reg_rdata <= pkt_cnt_r;
        REG_DROP_CNT: o_reg_rdata <= drop_cnt_r;
        default: o_reg_rdata <= 32'h0000_0000;
      endcase
  end

  // buffers seen since the last header, for checking the count
  logic [15:0] seen_r;
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      seen_r <= 16'h0000;
    else if (o_hdr_valid)
      seen_r <= 16'h0000;
    else if (o_buf_valid)
      seen_r <= seen_r + 16'h0001;
  end

  a_single_buffer: assert property ( // see RULE1
    o_hdr_valid && !feat_r[F_MRG] |-> o_hdr_num_buffers == 16'h0001)
    else $error("more than one buffer without merging");
  a_buf_full: assert property ( // see RULE2
    o_buf_valid ##1 o_buf_valid |-> $past(o_buf_len) == blen_r)
    else $error("non-last buffer not filled");
  a_used_count: assert property ( // see RULE3
    o_hdr_valid |-> o_hdr_num_buffers == seen_r && !o_buf_valid)
    else $error("used count differs from buffers filled");
  a_flags_zero: assert property ( // see RULE4
    o_hdr_valid && !feat_r[F_CSUM] |-> o_hdr_flags == 8'h00)
    else $error("flags set without receive checksum");
  a_gso_none: assert property ( // see RULE5
    o_hdr_valid && !(feat_r[F_TSO4] | feat_r[F_TSO6] | feat_r[F_UFO])
    |-> o_hdr_gso_type == GSO_NONE)
    else $error("offload type without segmentation");
  a_ecn_drop: assert property ( // see RULE6
    take && gso_on && i_pkt_ecn && !feat_r[F_ECN] |=> o_pkt_drop
    ##2 !o_hdr_valid)
    else $error("ECN packet delivered without ECN");
  a_gso_csum: assert property ( // see RULE8
    o_hdr_valid && o_hdr_gso_type != GSO_NONE
    |-> (o_hdr_flags & FLG_NEEDS_CSUM) != 8'h00 && o_hdr_gso_size == mss_r)
    else $error("offload without needs-checksum or size");
  a_rsc_flag: assert property ( // see RULE9
    o_hdr_valid && (o_hdr_flags & FLG_RSC_INFO) != 8'h00
    |-> feat_r[F_RSC] && o_hdr_gso_type != GSO_NONE)
    else $error("coalescing flag set wrongly");
  a_ack_bad: assert property ( // see RULE16
    cmd_end && cmd_cnt_r != 2'd2 |=> o_ack_valid && o_ack_byte == ACK_ERR)
    else $error("malformed command not refused");
  a_promisc_all: assert property ( // see RULE18
    i_filt_req && promisc_r |=> o_filt_valid && o_filt_pass)
    else $error("promiscuous packet dropped");
  a_nobcast_blk: assert property ( // see RULE22
    i_filt_req && !promisc_r && nobcast_r && i_filt_dst == VNR_DST_BCAST
    |=> !o_filt_pass)
    else $error("broadcast passed while suppressed");
endmodule

// [core/vnr_pkg.sv]
// Overview of operation
// RULE1: header carries buffer count; exactly one buffer, count 1, without merging.
// RULE2: every buffer but the last of a packet is filled to its full length.
// RULE3: all buffers of one packet are handed back as used together.
// RULE4: without receive checksum, flags are zero; packets arrive fully summed.
// RULE5: offload type none without segmentation; each type only if negotiated.
// RULE6: ECN segmented TCP dropped unless ECN negotiated; then ECN bit set.
// RULE7: needs-checksum only after validation; start and offset complete the sum.
// RULE8: any offload type also sets needs-checksum and writes segment size.
// RULE9: coalescing flag with extension and offload; fields carry segment counts.
// RULE10: with segmentation negotiated, header length covers all headers.
// RULE11: data-valid only with receive checksum and one validated level.
// RULE12: driver ignores flag bits it does not know.
// RULE13: driver reads start and offset only with needs-checksum, no coalescing.
// RULE14: driver treats header length only as a hint.
// RULE15: driver trusts the checksum only with needs-checksum or data-valid.
// RULE16: command is class, code, data, then ack byte: 0 ok, 1 error.
// RULE17: basic control accepts class 0 promiscuous and all-multicast, data 0/1.
// RULE18: promiscuous passes every packet, overriding all other filter modes.
// RULE19: extra control accepts all-unicast code 2; passes every unicast.
// RULE20: no-multicast code 3 blocks multicast even with all-multicast; not bcast.
// RULE21: no-unicast code 4 blocks unicast even with all-unicast.
// RULE22: no-broadcast code 5 blocks broadcast even with all-multicast.
package vnr_pkg;
  // header geometry
  localparam int HDR_BYTES = 12;
  // feature register bit positions
  localparam int F_MRG = 0;
  localparam int F_CSUM = 1;
  localparam int F_TSO4 = 2;
  localparam int F_TSO6 = 3;
  localparam int F_UFO = 4;
  localparam int F_ECN = 5;
  localparam int F_RSC = 6;
  localparam int F_CRX = 7;
  localparam int F_CRXX = 8;
  localparam int FEAT_W = 9;
  localparam logic [FEAT_W-1:0] FEAT_RST = 9'h000;
  // register offsets
  localparam logic [7:0] REG_FEATURES = 8'h00;
  localparam logic [7:0] REG_FILTER = 8'h04;
  localparam logic [7:0] REG_PKT_CNT = 8'h08;
  localparam logic [7:0] REG_DROP_CNT = 8'h0C;
  // header flag bits and offload types
  localparam logic [7:0] FLG_NEEDS_CSUM = 8'h01;
  localparam logic [7:0] FLG_DATA_VALID = 8'h02;
  localparam logic [7:0] FLG_RSC_INFO = 8'h04;
  localparam logic [7:0] GSO_NONE = 8'h00;
  localparam logic [7:0] GSO_TCPV4 = 8'h01;
  localparam logic [7:0] GSO_UDP = 8'h03;
  localparam logic [7:0] GSO_TCPV6 = 8'h04;
  localparam logic [7:0] GSO_ECN = 8'h80;
  // control command encodings
  localparam logic [7:0] CLS_RX = 8'h00;
  localparam logic [7:0] ACK_OK = 8'h00;
  localparam logic [7:0] ACK_ERR = 8'h01;
  localparam logic [7:0] CMD_PROMISC = 8'h00;
  localparam logic [7:0] CMD_ALLMULTI = 8'h01;
  localparam logic [7:0] CMD_ALLUNI = 8'h02;
  localparam logic [7:0] CMD_NOMULTI = 8'h03;
  localparam logic [7:0] CMD_NOUNI = 8'h04;
  localparam logic [7:0] CMD_NOBCAST = 8'h05;
  // requested offload kind, destination kind and framing state
  typedef enum logic [1:0] {
    VNR_OFF_NONE = 2'b00,
    VNR_OFF_TCP4 = 2'b01,
    VNR_OFF_TCP6 = 2'b10,
    VNR_OFF_UDP = 2'b11
  } vnr_off_t;
  typedef enum logic [1:0] {
    VNR_DST_UNI = 2'b00,
    VNR_DST_MULTI = 2'b01,
    VNR_DST_BCAST = 2'b10
  } vnr_dst_t;
  typedef enum logic [1:0] {
    VNR_ST_IDLE = 2'b00,
    VNR_ST_SPLIT = 2'b01,
    VNR_ST_HDR = 2'b10
  } vnr_state_t;
endpackage

// [tb/vnr_drv_model.sv]
`timescale 1ns/1ps
// guest driver end of the control queue: one command per start pulse
module vnr_drv_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic [23:0] i_bytes,
  input wire logic [2:0] i_count,
  input wire logic i_slow,
  output logic o_busy,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_byte,
  output logic o_cmd_last
);
  logic [31:0] sh_r;
  logic [2:0] left_r;
  logic gap_r;
  // class, code and data leave in that order; the ack is the device's
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_busy <= 1'b0;
      o_cmd_valid <= 1'b0;
      o_cmd_last <= 1'b0;
      o_cmd_byte <= 8'h00;
      sh_r <= 32'h0000_0000;
      left_r <= 3'd0;
      gap_r <= 1'b0;
    end
    else
    begin
      o_cmd_valid <= 1'b0;
      o_cmd_last <= 1'b0;
      // idle lane toggles so a stale byte never passes for a command
      o_cmd_byte <= ~o_cmd_byte;
      if (i_start && !o_busy)
      begin
        sh_r <= {i_bytes, 8'ha5}; // class first
        left_r <= i_count;
        o_busy <= 1'b1;
      end
      else if (left_r == 3'd0)
        o_busy <= 1'b0;
      else if (i_slow && !gap_r)
        gap_r <= 1'b1; // slow driver idles before each byte
      else
      begin
        gap_r <= 1'b0;
        o_cmd_valid <= 1'b1;
        o_cmd_byte <= sh_r[31:24];
        o_cmd_last <= (left_r == 3'd1); // the last counted byte closes it, the data byte when the count is 3
        sh_r <= {sh_r[23:0], 8'h00};
        left_r <= left_r - 3'd1;
      end
    end
  end
endmodule

// [tb/test_net_rx_header_and_rx_filter.sv]
`timescale 1ns/1ps
module test_net_rx_header_and_rx_filter;
  import vnr_pkg::*;
  localparam int LEN_W = 17;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [31:0] i_reg_wdata = 32'h0000_0000;
  logic i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic i_pkt_req = 1'b0;
  logic [LEN_W-1:0] i_pkt_len = '0;
  logic [LEN_W-1:0] i_buf_len = '0;
  vnr_off_t i_pkt_off = VNR_OFF_NONE;
  logic i_pkt_ecn = 1'b0;
  logic i_csum_partial = 1'b0, i_csum_checked = 1'b0, i_csum_verified = 1'b0;
  logic [15:0] i_pkt_mss = 16'h0000;
  logic [15:0] i_pkt_hdr_len = 16'h0000;
  logic [15:0] i_csum_start = 16'h0000;
  logic [15:0] i_csum_offset = 16'h0000;
  logic [15:0] i_rsc_segs = 16'h0000, i_rsc_dups = 16'h0000;
  logic i_filt_req = 1'b0;
  vnr_dst_t i_filt_dst = VNR_DST_UNI;
  logic i_filt_addr_match = 1'b0;
  logic drv_start = 1'b0;
  logic drv_slow = 1'b0;
  logic [23:0] drv_bytes = 24'h00_0000;
  logic [2:0] drv_count = 3'h3;
  logic drv_busy, i_cmd_valid, i_cmd_last, o_pkt_ready, o_buf_valid;
  logic o_hdr_valid, o_pkt_drop, o_ack_valid, o_filt_valid, o_filt_pass;
  logic [7:0] i_cmd_byte, o_ack_byte, o_hdr_flags, o_hdr_gso_type;
  logic [15:0] o_hdr_len, o_hdr_gso_size, o_hdr_csum_start;
  logic [15:0] o_hdr_csum_offset, o_hdr_num_buffers;
  logic [31:0] o_reg_rdata;
  logic [LEN_W-1:0] o_buf_len;
  logic [FEAT_W-1:0] feat = FEAT_RST;
  logic [5:0] fst = 6'h00;
  logic rd_d = 1'b0;
  int failures = 0;
  int cmp_count = 0;
  int nbuf = 0, n_hdr = 0, n_drop = 0;
  logic [96:0] q_hdr[$];
  logic [LEN_W-1:0] q_buf[$];
  logic [31:0] q_rd[$];
  logic [7:0] q_ack[$];
  logic q_flt[$];

  vnr_rx_framer #(.LEN_W(LEN_W)) uut (
    .i_clk, .i_resetn, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .i_pkt_req, .o_pkt_ready, .i_pkt_len, .i_buf_len,
    .i_pkt_off, .i_pkt_ecn, .i_pkt_mss, .i_pkt_hdr_len, .i_csum_partial,
    .i_csum_checked, .i_csum_verified, .i_csum_start, .i_csum_offset,
    .i_rsc_segs, .i_rsc_dups, .o_buf_valid, .o_buf_len, .o_hdr_valid,
    .o_hdr_flags, .o_hdr_gso_type, .o_hdr_len, .o_hdr_gso_size,
    .o_hdr_csum_start, .o_hdr_csum_offset, .o_hdr_num_buffers, .o_pkt_drop,
    .i_cmd_valid, .i_cmd_byte, .i_cmd_last, .o_ack_valid, .o_ack_byte,
    .i_filt_req, .i_filt_dst, .i_filt_addr_match, .o_filt_valid, .o_filt_pass
  );
  vnr_drv_model drv (
    .i_clk, .i_resetn, .i_start(drv_start), .i_bytes(drv_bytes),
    .i_count(drv_count), .i_slow(drv_slow), .o_busy(drv_busy),
    .o_cmd_valid(i_cmd_valid), .o_cmd_byte(i_cmd_byte), .o_cmd_last(i_cmd_last)
  );

  // 200 MHz
  always #2.5 i_clk = ~i_clk;

  task automatic chk(input logic [96:0] seen, input logic [96:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [96:0] obs();
    logic [15:0] sz;
    logic [31:0] co;
    // driver view: size only with offload, start and offset only under
    // needs-checksum, data-valid or coalescing, length a hint
    sz = o_hdr_gso_type != GSO_NONE ? o_hdr_gso_size : 16'h0000;
    co = |o_hdr_flags[2:0] ? {o_hdr_csum_start, o_hdr_csum_offset} : 32'h0;
    return {1'b0, o_hdr_flags, o_hdr_gso_type, o_hdr_num_buffers,
      o_hdr_len, sz, co};
  endfunction

  // watcher: every result pulse takes the oldest note of its kind
  always @(posedge i_clk)
  begin
    rd_d <= i_reg_rd;
    if (rd_d)
      chk(97'(o_reg_rdata), 97'(q_rd.pop_front())); // register map
    if (o_ack_valid === 1'b1)
      chk(97'(o_ack_byte), 97'(q_ack.pop_front())); // ack
    if (o_filt_valid === 1'b1)
      chk(97'(o_filt_pass), 97'(q_flt.pop_front())); // pass
    if (o_buf_valid === 1'b1)
    begin
      nbuf++;
      chk(97'(o_buf_len), 97'(q_buf.pop_front())); // fill
      chk(97'(o_pkt_ready), 97'(1'b0)); // busy while filling
    end
    if (o_hdr_valid === 1'b1)
    begin
      chk(97'(nbuf), 97'(o_hdr_num_buffers)); // together
      nbuf = 0;
      chk(obs(), q_hdr.pop_front()); // header
    end
    if (o_pkt_drop === 1'b1)
      chk({1'b1, 96'h0}, q_hdr.pop_front()); // refused
  end

  // register cycle: w high writes, low reads and notes the expected word
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    i_reg_wr <= w;
    i_reg_rd <= !w;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    if (!w)
      q_rd.push_back(d);
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b0;
  endtask

  task automatic setf(input logic [FEAT_W-1:0] f);
    feat = f;
    bus(1'b1, REG_FEATURES, 32'(f));
    bus(1'b0, REG_FEATURES, 32'(f));
  endtask

  // one command through the driver model, then a sweep of the filter
  task automatic cmd(input logic [7:0] c, input logic [7:0] k,
                     input logic [7:0] d, input logic [2:0] n);
    logic ok, m, p;
    vnr_dst_t dst;
    ok = n == 3'd3 && c == CLS_RX && d <= 8'h01 && k <= CMD_NOBCAST &&
      (k <= CMD_ALLMULTI ? feat[F_CRX] : feat[F_CRXX]);
    if (ok)
      fst[k[2:0]] = d[0]; // filter bits follow the command code
    q_ack.push_back(ok ? ACK_OK : ACK_ERR);
    @(posedge i_clk);
    drv_start <= 1'b1;
    drv_bytes <= {c, k, d};
    drv_count <= n;
    drv_slow <= 1'($urandom);
    @(posedge i_clk);
    drv_start <= 1'b0;
    @(posedge i_clk);
    for (int t = 0; t < 40 && drv_busy !== 1'b0; t++)
      @(posedge i_clk);
    bus(1'b0, REG_FILTER, 32'(fst));
    for (int j = 0; j < 6; j++)
    begin
      dst = vnr_dst_t'(j / 2);
      m = 1'(j % 2);
      p = dst == VNR_DST_BCAST ? !fst[5] : // no-bcast
        dst == VNR_DST_MULTI ? (m || fst[1]) && !fst[3] :
        (m || fst[2]) && !fst[4]; // unicast
      q_flt.push_back(p || fst[0]); // promisc wins
      @(posedge i_clk);
      i_filt_req <= 1'b1;
      i_filt_dst <= dst;
      i_filt_addr_match <= m;
    end
    @(posedge i_clk);
    i_filt_req <= 1'b0;
  endtask

  task automatic pkt(input int len, input int bsz, input vnr_off_t off,
                     input logic ecn);
    logic offl, needs, dv, rsc, seg;
    logic [7:0] gso, flg;
    logic [31:0] r1, r2, r3;
    int nb, tot;
    r1 = $urandom;
    r2 = $urandom;
    r3 = $urandom;
    tot = len + HDR_BYTES;
    seg = feat[F_TSO4] | feat[F_TSO6] | feat[F_UFO];
    offl = feat[F_CSUM] && off != VNR_OFF_NONE && feat[int'(off) + 1];
    ecn = ecn && offl && off != VNR_OFF_UDP;
    gso = !offl ? GSO_NONE : off == VNR_OFF_TCP4 ? GSO_TCPV4 :
      off == VNR_OFF_TCP6 ? GSO_TCPV6 : GSO_UDP;
    if (ecn)
      gso = gso | GSO_ECN; // marked
    needs = offl || (r3[0] && r3[1]); // offload
    dv = r3[2] && !needs;
    rsc = feat[F_RSC] && offl;
    flg = !feat[F_CSUM] ? 8'h00 : (needs ? FLG_NEEDS_CSUM : 8'h00) |
      (dv ? FLG_DATA_VALID : 8'h00) | (rsc ? FLG_RSC_INFO : 8'h00);
    nb = feat[F_MRG] ? (tot + bsz - 1) / bsz : 1; // count
    if (!feat[F_MRG] && tot > bsz || ecn && !feat[F_ECN] || bsz < HDR_BYTES)
    begin
      q_hdr.push_back({1'b1, 96'h0});
      n_drop++;
    end
    else
    begin
      q_hdr.push_back({1'b0, flg, gso, 16'(nb), seg ? r1[31:16] : 16'h0000,
        offl ? r1[15:0] : 16'h0000,
        rsc ? r2 : flg[0] ? r3 : 32'h0000_0000});
      n_hdr++;
      for (int t = 0; t < nb; t++)
        q_buf.push_back(LEN_W'(t < nb - 1 ? bsz : tot - (nb - 1) * bsz));
    end
    @(posedge i_clk);
    i_pkt_req <= 1'b1;
    i_pkt_len <= LEN_W'(len);
    i_buf_len <= LEN_W'(bsz);
    i_pkt_off <= off;
    i_pkt_ecn <= ecn;
    i_pkt_mss <= r1[15:0];
    i_pkt_hdr_len <= r1[31:16];
    i_rsc_segs <= r2[31:16];
    i_rsc_dups <= r2[15:0];
    i_csum_partial <= r3[0];
    i_csum_checked <= r3[1];
    i_csum_verified <= r3[2];
    i_csum_start <= r3[31:16];
    i_csum_offset <= r3[15:0];
    @(posedge i_clk);
    i_pkt_req <= 1'b0;
    for (int t = 0; t < 400; t++)
    begin
      @(posedge i_clk);
      if (o_hdr_valid === 1'b1 || o_pkt_drop === 1'b1)
        break;
    end
  endtask

  initial
  begin
    int r;
    void'($urandom(32'hac9d));
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    bus(1'b0, REG_FEATURES, 32'(FEAT_RST));
    bus(1'b0, 8'h10, 32'h0000_0000); // unmapped reads as zero
    bus(1'b1, REG_FILTER, 32'h0000_003f); // read-only, must not stick
    cmd(CLS_RX, CMD_PROMISC, 8'h01, 3'd3); // control not negotiated
    pkt(20, 16, VNR_OFF_NONE, 1'b0);
    pkt(20, 40, VNR_OFF_TCP4, 1'b0);
    setf(9'h001);
    pkt(20, 8, VNR_OFF_NONE, 1'b0);
    pkt(20, 16, VNR_OFF_NONE, 1'b0);
    pkt(36, 16, VNR_OFF_NONE, 1'b0);
    setf(9'h006);
    pkt(60, 200, VNR_OFF_TCP4, 1'b1);
    setf(9'h066);
    pkt(60, 200, VNR_OFF_TCP4, 1'b1);
    // random feature sets, each with a burst of packets
    for (int i = 0; i < 16; i++)
    begin
      setf(FEAT_W'($urandom));
      repeat (8)
        pkt(1 + $urandom % 300, 12 + $urandom % (feat[F_MRG] ? 60 : 400),
          vnr_off_t'($urandom % 4), 1'($urandom));
    end
    // command stream, odd lengths and bad fields mixed in
    for (int i = 0; i < 48; i++)
    begin
      if (i % 8 == 0)
        setf(FEAT_W'($urandom));
      r = $urandom % 8;
      cmd(($urandom % 8 == 0) ? 8'h01 : CLS_RX, 8'($urandom % 7),
        8'($urandom % 3), (r == 0) ? 3'd2 : (r == 1) ? 3'd4 : 3'd3);
    end
    bus(1'b0, REG_PKT_CNT, 32'(n_hdr));
    bus(1'b0, REG_DROP_CNT, 32'(n_drop));
    repeat (3) @(posedge i_clk);
    chk(97'(q_hdr.size() + q_buf.size() + q_ack.size() + q_flt.size()),
      97'(0));
    test_done();
  end

  // hang guard, far past the longest expected run
  initial
  begin
    #300000;
    failures++;
    test_done();
  end
endmodule
